/* hdl/crd_datapath.sv */
// Processor register datapath with AHB-Lite register access and core storage port
`timescale 1ns/10ps
//
// Notes on behaviour
// - Accumulator right shift drops low bits and copies sign into high bits.
// - Accumulator left shift rotates; top bit enters bottom each place.
// - Accumulator and auxiliary shift alone or as one double-length pair.
// - Opcodes 06, 07 and 27 use the auxiliary register as bit mask.
// - Any index register moves to or from accumulator or auxiliary directly.
// - Indexing adds sign-extended index to low 15 or 17 instruction bits.
// - Ordinary indirect replaces low 18 instruction bits from operand word.
// - Index-load/store indirect replaces bits 00-14 and 17, no indexing.
// - Display shows instruction when idle, entry register when keyboard active.
// - Entry register holds keyed value until transfer; keyboard clear zeroes it.
// - Sweep loads each storage word into entry register; read-storage loads only bus buffer and data register.
// - Normal exit adds one to program counter; storage address comes from storage address register.
// - Skip exit adds two to program counter.
// - Jump exit loads execution address into program counter.
// - Index registers supply address offsets and transfer values, never do arithmetic.
// - Bus buffer loads entry register shifted left by zero to three characters.
// - Double multiply keeps low 48 product bits; divide ends with remainder.
// - Float multiply keeps coefficient residue; float divide keeps remainder.
// - Decimal mode widens extended register to 53 bits, 13 digits plus sign.
// - Field length loads 1 to 12 by set and holds until next set.
// - All storage traffic passes through 28-bit data register with parity.
// - Storage address register holds 13-bit address of current word.
// - Bus loads of accumulator, auxiliary, extended high fold minus zero to positive zero.
// - Words are four 6-bit characters with one parity bit each.
module crd_datapath #(
  parameter int WORD_W = crd_pkg::WORD_W
) (
  // Clock and reset
  input  wire  logic                         ref_clk,
  input  wire  logic                         rstn,
  // AHB-Lite slave
  input  wire  logic                         hsel,
  input  wire  logic [31:0]                  haddr,
  input  wire  logic [1:0]                   htrans,
  input  wire  logic                         hwrite,
  input  wire  logic [2:0]                   hsize,
  input  wire  logic [31:0]                  hwdata,
  input  wire  logic                         hready,
  output logic       [31:0]                  hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // Core storage
  output logic       [crd_pkg::SADDR_W-1:0]  stor_addr,
  output logic       [crd_pkg::SDATA_W-1:0]  stor_wdata,
  output logic                               stor_we,
  output logic                               stor_re,
  input  wire  logic [crd_pkg::SDATA_W-1:0]  stor_rdata,
  input  wire  logic                         stor_ack,
  // Console
  input  wire  crd_pkg::crd_mode_t           mode,
  output logic       [WORD_W-1:0]            console_disp,
  output logic                               parity_err
);
  //////////////////////////////////////////////////////////////////////////////
  localparam int XW = crd_pkg::IDX_W;
  logic [WORD_W-1:0] acc_r, aux_r, instr_r, entry_r, buf_r, exth_r, extl_r;
  logic [4:0]        dech_r;
  logic [XW-1:0]     index_reg [3];
  logic [crd_pkg::PC_W-1:0]    pc_r;
  logic [crd_pkg::FLEN_W-1:0]  flen_r;
  logic [crd_pkg::SADDR_W-1:0] saddr_r;
  logic [crd_pkg::SDATA_W-1:0] sdata_r;
  logic              mask_hit_r;
  crd_pkg::crd_st_t  st_r;

  // Bus address phase capture
  logic        ap_valid_r, ap_write_r;
  logic [7:0]  ap_addr_r;
  wire         ap_take = hsel & hready & htrans[1];
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r  <= 8'h00;
    end else if (hready) begin
      ap_valid_r <= ap_take;
      ap_write_r <= hwrite;
      ap_addr_r  <= haddr[7:0];
    end
  end

  // Storage cycles stall the bus until acknowledged
  assign hreadyout = (st_r == crd_pkg::ST_IDLE);
  assign hresp     = 1'b0;
  // A stalled data phase must not write again on every held cycle
  wire wr_en = ap_valid_r & ap_write_r & hreadyout;
  wire [WORD_W-1:0] wd = hwdata[WORD_W-1:0];
  wire cmd_go = wr_en & (ap_addr_r == crd_pkg::R_CMD);
  crd_pkg::crd_cmd_t cmd;
  assign cmd = crd_pkg::crd_cmd_t'(wd[4:0]);
  wire [1:0]  sel  = wd[6:5];
  wire [15:0] arg  = wd[23:8];
  wire [1:0]  xsel = (sel == 2'h0) ? 2'h0 : sel - 2'h1;

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [WORD_W-1:0] posz(input logic [WORD_W-1:0] v);
    posz = (&v) ? '0 : v; // Minus zero folded to plus zero
  endfunction

  function automatic logic [WORD_W-1:0] shr(input logic [WORD_W-1:0] v, input int n);
    logic signed [WORD_W-1:0] s;
    s = v;
    shr = WORD_W'(s >>> n);
  endfunction

  function automatic logic [WORD_W-1:0] rol(input logic [WORD_W-1:0] v, input int n);
    rol = WORD_W'((v << n) | (v >> (WORD_W - n)));
  endfunction

  function automatic logic [crd_pkg::NCHAR-1:0] cpar(input logic [WORD_W-1:0] v);
    for (int i = 0; i < crd_pkg::NCHAR; i++)
      cpar[i] = ~^v[i*crd_pkg::CHAR_W +: crd_pkg::CHAR_W];
  endfunction

  wire [4:0] shn = arg[4:0] % 5'(WORD_W);
  wire [2*WORD_W-1:0] pair = {acc_r, aux_r};
  wire [5:0] pshn = arg[5:0];
  wire [2*WORD_W-1:0] pair_r = (2*WORD_W)'($signed(pair) >>> pshn);
  wire [2*WORD_W-1:0] pair_l = (2*WORD_W)'((pair << pshn) | (pair >> (7'd48 - {1'b0, pshn})));
  wire [5:0] opc = instr_r[crd_pkg::OP_LSB +: 6];
  wire is_mask = (opc == crd_pkg::OP_MASK0) | (opc == crd_pkg::OP_MASK1)
               | (opc == crd_pkg::OP_MASK2);
  wire [XW-1:0] xv = index_reg[xsel];
  wire [WORD_W-1:0] xv_ext = {{(WORD_W-XW){xv[XW-1]}}, xv};
  wire [crd_pkg::WADDR_W-1:0] wsum = instr_r[crd_pkg::WADDR_W-1:0] + xv;
  wire [crd_pkg::CADDR_W-1:0] csum = instr_r[crd_pkg::CADDR_W-1:0]
                                   + {{2{xv[XW-1]}}, xv};
  wire [WORD_W-1:0] rd_word = stor_rdata[WORD_W-1:0];
  wire [crd_pkg::NCHAR-1:0] rd_par = stor_rdata[crd_pkg::SDATA_W-1 -: crd_pkg::NCHAR];
  wire [1:0] bsh = arg[1:0];
  wire [WORD_W-1:0] buf_sh = WORD_W'(entry_r << (bsh * crd_pkg::CHAR_W));

  //////////////////////////////////////////////////////////////////////////////
  // Storage cycle sequencer: sweep/read and plain read/write
  logic st_sweep_r, st_wr_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r       <= crd_pkg::ST_IDLE;
      st_sweep_r <= 1'b0;
      st_wr_r    <= 1'b0;
    end else begin
      case (st_r)
        crd_pkg::ST_IDLE:
          if (cmd_go && (cmd == crd_pkg::CMD_SWEEP || cmd == crd_pkg::CMD_SREAD
                         || cmd == crd_pkg::CMD_SWRITE)) begin
            st_r       <= crd_pkg::ST_ADDR;
            st_sweep_r <= (cmd == crd_pkg::CMD_SWEEP);
            st_wr_r    <= (cmd == crd_pkg::CMD_SWRITE);
          end
        crd_pkg::ST_ADDR: st_r <= crd_pkg::ST_DATA;
        crd_pkg::ST_DATA: if (stor_ack) st_r <= crd_pkg::ST_IDLE;
        default:          st_r <= crd_pkg::ST_IDLE;
      endcase
    end
  end
  assign stor_re = (st_r == crd_pkg::ST_DATA) & ~st_wr_r;
  assign stor_we = (st_r == crd_pkg::ST_DATA) & st_wr_r;
  assign stor_addr  = saddr_r;
  assign stor_wdata = sdata_r;
  wire rd_done = stor_re & stor_ack;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      saddr_r    <= '0;
      sdata_r    <= '0;
      parity_err <= 1'b0;
    end else begin
      if (st_r == crd_pkg::ST_IDLE && cmd_go && cmd == crd_pkg::CMD_SWEEP)
        saddr_r <= saddr_r + 1'b1;
      else if (wr_en && ap_addr_r == crd_pkg::R_SADDR)
        saddr_r <= wd[crd_pkg::SADDR_W-1:0];
      if (rd_done) begin
        sdata_r    <= stor_rdata;
        parity_err <= parity_err | (rd_par != cpar(rd_word));
      end else if (wr_en && ap_addr_r == crd_pkg::R_SDATA)
        sdata_r <= {cpar(wd), wd};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Accumulator and auxiliary
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= '0;
      aux_r <= '0;
      mask_hit_r <= 1'b0;
    end else if (wr_en && ap_addr_r == crd_pkg::R_ACC) begin
      acc_r <= posz(wd);
    end else if (wr_en && ap_addr_r == crd_pkg::R_AUX) begin
      aux_r <= posz(wd);
    end else if (cmd_go) begin
      case (cmd)
        crd_pkg::CMD_SHR_A:  acc_r <= shr(acc_r, shn);
        crd_pkg::CMD_SHL_A:  acc_r <= rol(acc_r, shn);
        crd_pkg::CMD_SHR_Q:  aux_r <= shr(aux_r, shn);
        crd_pkg::CMD_SHL_Q:  aux_r <= rol(aux_r, shn);
        crd_pkg::CMD_SHR_AQ: {acc_r, aux_r} <= pair_r;
        crd_pkg::CMD_SHL_AQ: {acc_r, aux_r} <= pair_l;
        crd_pkg::CMD_MASK: begin
          mask_hit_r <= is_mask;
          if (is_mask) acc_r <= acc_r & aux_r;
        end
        crd_pkg::CMD_X2A: acc_r <= xv_ext;
        crd_pkg::CMD_X2Q: aux_r <= xv_ext;
        crd_pkg::CMD_XFER: begin
          if (sel == 2'h0) acc_r <= entry_r;
          if (sel == 2'h1) aux_r <= entry_r;
        end
        default: ;
      endcase
    end
  end

  // Index registers: loads only, no arithmetic of their own
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 3; i++) index_reg[i] <= '0;
    end else if (wr_en && ap_addr_r >= crd_pkg::R_IDX1 && ap_addr_r <= crd_pkg::R_IDX3) begin
      index_reg[2'(ap_addr_r[3:2] - 2'h1)] <= wd[XW-1:0];
    end else if (cmd_go && cmd == crd_pkg::CMD_A2X) begin
      index_reg[xsel] <= acc_r[XW-1:0];
    end else if (cmd_go && cmd == crd_pkg::CMD_Q2X) begin
      index_reg[xsel] <= aux_r[XW-1:0];
    end else if (cmd_go && cmd == crd_pkg::CMD_XFER && sel == 2'h3) begin
      index_reg[2] <= entry_r[XW-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Instruction register and program counter
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      instr_r <= '0;
    end else if (wr_en && ap_addr_r == crd_pkg::R_INSTR) begin
      instr_r <= wd;
    end else if (cmd_go && cmd == crd_pkg::CMD_INDEX) begin
      if (arg[0])
        instr_r[crd_pkg::CADDR_W-1:0] <= csum;
      else
        instr_r[crd_pkg::WADDR_W-1:0] <= wsum;
    end else if (cmd_go && cmd == crd_pkg::CMD_IND) begin
      instr_r[crd_pkg::IND_W-1:0] <= buf_r[crd_pkg::IND_W-1:0];
    end else if (cmd_go && cmd == crd_pkg::CMD_INDX) begin
      instr_r[crd_pkg::WADDR_W-1:0] <= buf_r[crd_pkg::WADDR_W-1:0];
      instr_r[crd_pkg::CADDR_W] <= buf_r[crd_pkg::CADDR_W];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pc_r <= '0;
    end else if (wr_en && ap_addr_r == crd_pkg::R_PC) begin
      pc_r <= wd[crd_pkg::PC_W-1:0];
    end else if (cmd_go) begin
      case (cmd)
        crd_pkg::CMD_EXIT_N: pc_r <= pc_r + 15'h0001;
        crd_pkg::CMD_EXIT_S: pc_r <= pc_r + 15'h0002;
        crd_pkg::CMD_EXIT_J: pc_r <= instr_r[crd_pkg::PC_W-1:0];
        crd_pkg::CMD_XFER: if (sel == 2'h2) pc_r <= entry_r[crd_pkg::PC_W-1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Entry register, bus buffer, field length
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      entry_r <= '0;
    end else if (rd_done && st_sweep_r) begin
      entry_r <= rd_word;
    end else if (cmd_go && cmd == crd_pkg::CMD_KCLR) begin
      entry_r <= '0;
    end else if (wr_en && ap_addr_r == crd_pkg::R_ENTRY && mode.kbd_active) begin
      entry_r <= wd;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      buf_r <= '0;
    end else if (rd_done) begin
      buf_r <= rd_word;
    end else if (cmd_go && cmd == crd_pkg::CMD_BUFSH) begin
      buf_r <= buf_sh;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flen_r <= crd_pkg::FLEN_MIN;
    end else if (cmd_go && cmd == crd_pkg::CMD_SETLEN && arg[3:0] >= crd_pkg::FLEN_MIN
                 && arg[3:0] <= crd_pkg::FLEN_MAX) begin
      flen_r <= arg[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Extended register: product low half, remainder, residue, decimal
  wire [4*WORD_W-1:0] prod = {{(2*WORD_W){1'b0}}, pair} * {{(2*WORD_W){1'b0}}, exth_r, extl_r};
  wire [2*WORD_W-1:0] divisor = {{WORD_W{1'b0}}, buf_r};
  wire [2*WORD_W-1:0] rem = (buf_r == '0) ? {exth_r, extl_r} : {exth_r, extl_r} % divisor;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      exth_r <= '0;
      extl_r <= '0;
      dech_r <= '0;
    end else if (wr_en && ap_addr_r == crd_pkg::R_EXTH) begin
      exth_r <= posz(wd);
    end else if (wr_en && ap_addr_r == crd_pkg::R_EXTL) begin
      extl_r <= wd;
    end else if (wr_en && ap_addr_r == crd_pkg::R_DECH && mode.dec_mode) begin
      dech_r <= wd[4:0];
    end else if (cmd_go) begin
      case (cmd)
        crd_pkg::CMD_DPMUL: {exth_r, extl_r} <= prod[2*WORD_W-1:0];
        crd_pkg::CMD_DPDIV: {exth_r, extl_r} <= rem;
        crd_pkg::CMD_FPRES: {exth_r, extl_r} <= arg[0] ? rem : prod[2*WORD_W-1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Console display and read mux
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      console_disp <= '0;
    else if (mode.kbd_active)
      console_disp <= entry_r;
    else if (!mode.running)
      console_disp <= instr_r;
  end

  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    case (ap_addr_r)
      crd_pkg::R_ACC:   rmux[WORD_W-1:0] = acc_r;
      crd_pkg::R_AUX:   rmux[WORD_W-1:0] = aux_r;
      crd_pkg::R_INSTR: rmux[WORD_W-1:0] = instr_r;
      crd_pkg::R_ENTRY: rmux[WORD_W-1:0] = entry_r;
      crd_pkg::R_PC:    rmux[crd_pkg::PC_W-1:0] = pc_r;
      crd_pkg::R_IDX1:  rmux[XW-1:0] = index_reg[0];
      crd_pkg::R_IDX2:  rmux[XW-1:0] = index_reg[1];
      crd_pkg::R_IDX3:  rmux[XW-1:0] = index_reg[2];
      crd_pkg::R_BUF:   rmux[WORD_W-1:0] = buf_r;
      crd_pkg::R_EXTH:  rmux[WORD_W-1:0] = exth_r;
      crd_pkg::R_EXTL:  rmux[WORD_W-1:0] = extl_r;
      crd_pkg::R_DECH:  rmux[4:0] = dech_r;
      crd_pkg::R_FLEN:  rmux[crd_pkg::FLEN_W-1:0] = flen_r;
      crd_pkg::R_SADDR: rmux[crd_pkg::SADDR_W-1:0] = saddr_r;
      crd_pkg::R_SDATA: rmux[crd_pkg::SDATA_W-1:0] = sdata_r;
      crd_pkg::R_STAT:  rmux[3:0] = {mask_hit_r, parity_err, st_r};
      crd_pkg::R_DISP:  rmux[WORD_W-1:0] = console_disp;
      default:          rmux = 32'h0000_0000;
    endcase
  end
  assign hrdata = rmux;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Shifts may leave all ones legitimately; only loaded values are folded
  no_negzero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wr_en && ap_addr_r == crd_pkg::R_ACC) |=> !(&acc_r))
    else $error("negative zero held");
  pc_normal_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cmd_go && cmd == crd_pkg::CMD_EXIT_N && !(wr_en && ap_addr_r == crd_pkg::R_PC))
    |=> pc_r == $past(pc_r) + 15'h0001) else $error("normal exit step wrong");
  pc_skip_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cmd_go && cmd == crd_pkg::CMD_EXIT_S) |=> pc_r == $past(pc_r) + 15'h0002)
    else $error("skip exit step wrong");
  pc_jump_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cmd_go && cmd == crd_pkg::CMD_EXIT_J) |=> pc_r == $past(instr_r[14:0]))
    else $error("jump target wrong");
  flen_range_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    flen_r >= crd_pkg::FLEN_MIN && flen_r <= crd_pkg::FLEN_MAX)
    else $error("field length out of range");
  kbd_disp_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode.kbd_active |=> console_disp == $past(entry_r))
    else $error("display not entry");
  stor_addr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (stor_re || stor_we) |=> $stable(stor_addr))
    else $error("address moved during storage cycle");
  sweep_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rd_done && st_sweep_r) |=> entry_r == $past(rd_word))
    else $error("sweep word lost");
  stor_wait_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st_r == crd_pkg::ST_ADDR) |=> (st_r == crd_pkg::ST_DATA) && !hreadyout)
    else $error("storage cycle skipped");
  cov_sweep_c: cover property (@(posedge ref_clk) rd_done && st_sweep_r);
  cov_jump_c:  cover property (@(posedge ref_clk) cmd_go && cmd == crd_pkg::CMD_EXIT_J);
  cov_mask_c:  cover property (@(posedge ref_clk) cmd_go && cmd == crd_pkg::CMD_MASK && is_mask);
endmodule // crd_datapath

/* hdl/crd_pkg.sv */
// Package: constants and carriers for the processor register datapath
package crd_pkg;
  localparam int WORD_W   = 24;
  localparam int CHAR_W   = 6;
  localparam int NCHAR    = 4;
  localparam int IDX_W    = 15;
  localparam int PC_W     = 15;
  localparam int SADDR_W  = 13;
  localparam int SDATA_W  = 28;
  localparam int WADDR_W  = 15;
  localparam int CADDR_W  = 17;
  localparam int IND_W    = 18;
  localparam int DEC_W    = 53;
  localparam int FLEN_W   = 4;
  localparam logic [3:0] FLEN_MIN = 4'h1;
  localparam logic [3:0] FLEN_MAX = 4'hc;
  localparam logic [5:0] OP_MASK0 = 6'h06;
  localparam logic [5:0] OP_MASK1 = 6'h07;
  localparam logic [5:0] OP_MASK2 = 6'h17;
  localparam int OP_LSB   = 18;

  // Register bus byte offsets
  localparam logic [7:0] R_ACC   = 8'h00;
  localparam logic [7:0] R_AUX   = 8'h04;
  localparam logic [7:0] R_INSTR = 8'h08;
  localparam logic [7:0] R_ENTRY = 8'h0c;
  localparam logic [7:0] R_PC    = 8'h10;
  localparam logic [7:0] R_IDX1  = 8'h14;
  localparam logic [7:0] R_IDX2  = 8'h18;
  localparam logic [7:0] R_IDX3  = 8'h1c;
  localparam logic [7:0] R_BUF   = 8'h20;
  localparam logic [7:0] R_EXTH  = 8'h24;
  localparam logic [7:0] R_EXTL  = 8'h28;
  localparam logic [7:0] R_DECH  = 8'h2c;
  localparam logic [7:0] R_FLEN  = 8'h30;
  localparam logic [7:0] R_SADDR = 8'h34;
  localparam logic [7:0] R_SDATA = 8'h38;
  localparam logic [7:0] R_CMD   = 8'h3c;
  localparam logic [7:0] R_STAT  = 8'h40;
  localparam logic [7:0] R_DISP  = 8'h44;

  // Command codes written to R_CMD[4:0]; argument in [23:8]
  typedef enum logic [4:0] {
    CMD_NOP      = 5'h00, CMD_SHR_A = 5'h01, CMD_SHL_A = 5'h02,
    CMD_SHR_Q    = 5'h03, CMD_SHL_Q = 5'h04, CMD_SHR_AQ = 5'h05,
    CMD_SHL_AQ   = 5'h06, CMD_MASK  = 5'h07, CMD_X2A   = 5'h08,
    CMD_X2Q      = 5'h09, CMD_A2X   = 5'h0a, CMD_Q2X   = 5'h0b,
    CMD_INDEX    = 5'h0c, CMD_IND   = 5'h0d, CMD_INDX  = 5'h0e,
    CMD_EXIT_N   = 5'h0f, CMD_EXIT_S = 5'h10, CMD_EXIT_J = 5'h11,
    CMD_XFER     = 5'h12, CMD_KCLR  = 5'h13, CMD_SWEEP = 5'h14,
    CMD_BUFSH    = 5'h15, CMD_DPMUL = 5'h16, CMD_DPDIV = 5'h17,
    CMD_FPRES    = 5'h18, CMD_SETLEN = 5'h19, CMD_SREAD = 5'h1a,
    CMD_SWRITE   = 5'h1b
  } crd_cmd_t;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ADDR = 2'b01, ST_DATA = 2'b11} crd_st_t;

  typedef struct packed {
    logic        running;
    logic        kbd_active;
    logic        dec_mode;
  } crd_mode_t;
endpackage

/* tb/cpu_register_datapath_tb.sv */
// Self-checking bench for the register datapath
`timescale 1ns/10ps
module cpu_register_datapath_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, lat = 2'h0;
  logic hwrite = 1'b0;
  crd_pkg::crd_mode_t mode = '0;
  logic hreadyout, hresp, stor_we, stor_re, stor_ack, parity_err;
  logic [12:0] stor_addr;
  logic [27:0] stor_wdata, stor_rdata;
  logic [23:0] console_disp, seed = 24'h23, a, q, ins, e;
  logic [47:0] aq;
  logic [14:0] p, x;
  logic [4:0] n;
  logic [1:0] sel;
  int num_errors = 0, tests_run = 0;
  always #12.5 ref_clk = ~ref_clk;
  crd_datapath dut_u (.ref_clk, .rstn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .stor_addr, .stor_wdata, .stor_we, .stor_re, .stor_rdata, .stor_ack,
    .mode, .console_disp, .parity_err);
  crd_stor_model stor_u (.ref_clk, .rstn, .stor_addr, .stor_wdata, .stor_we,
    .stor_re, .lat, .stor_rdata, .stor_ack);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] lfsr(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction
  function automatic logic [27:0] sword(input logic [3:0] i);
    logic [23:0] d;
    logic [3:0]  p;
    d = {6{i}} ^ 24'ha5c3e1;
    for (int k = 0; k < 4; k++) p[k] = ~^d[6*k+:6];
    return {p, d};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Ready sampled mid-cycle, so the edge that updates it cannot race us
  task automatic wait_rdy;
    do @(negedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(posedge ref_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    haddr <= {24'h0, ad};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
  endtask
  task automatic cmd(input crd_pkg::crd_cmd_t c, input logic [1:0] s, input logic [15:0] g);
    bus(1'b1, crd_pkg::R_CMD, {8'h0, g, 1'b0, s, c});
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    bus(1'b0, crd_pkg::R_FLEN, 32'h0);
    chk("flen_reset", rd, 32'h1);
    bus(1'b0, 8'h80, 32'h0);
    chk("unmapped", rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      a = seed;
      seed = lfsr(seed);
      q = seed;
      n = (i == 0) ? 5'h17 : 5'(seed % 24);
      bus(1'b1, crd_pkg::R_ACC, {8'h0, a});
      cmd(crd_pkg::CMD_SHR_A, 2'h0, {11'h0, n});
      bus(1'b0, crd_pkg::R_ACC, 32'h0);
      chk("shr_acc", rd, {8'h0, 24'($signed(a) >>> n)});
      bus(1'b1, crd_pkg::R_ACC, {8'h0, a});
      cmd(crd_pkg::CMD_SHL_A, 2'h0, {11'h0, n});
      aq = {a, a} << n;
      bus(1'b0, crd_pkg::R_ACC, 32'h0);
      chk("shl_acc", rd, {8'h0, aq[47:24]});
      bus(1'b1, crd_pkg::R_ACC, {8'h0, a});
      bus(1'b1, crd_pkg::R_AUX, {8'h0, q});
      cmd(crd_pkg::CMD_SHR_AQ, 2'h0, {11'h0, n});
      aq = 48'($signed({a, q}) >>> n);
      bus(1'b0, crd_pkg::R_ACC, 32'h0);
      chk("shr_pair_hi", rd, {8'h0, aq[47:24]});
      bus(1'b0, crd_pkg::R_AUX, 32'h0);
      chk("shr_pair_lo", rd, {8'h0, aq[23:0]});
      sel = 2'(i % 3 + 1);
      x = aq[38:24];
      cmd(crd_pkg::CMD_A2X, sel, 16'h0);
      bus(1'b0, {3'h0, sel, 2'b00} + 8'h10, 32'h0);
      chk("acc_to_index", rd, {17'h0, x});
      seed = lfsr(seed);
      bus(1'b1, crd_pkg::R_INSTR, {8'h0, seed});
      cmd(crd_pkg::CMD_INDEX, sel, {15'h0, i[0]});
      ins = i[0] ? {seed[23:17], seed[16:0] + {{2{x[14]}}, x}}
                 : {seed[23:15], seed[14:0] + x};
      bus(1'b0, crd_pkg::R_INSTR, 32'h0);
      chk("indexing", rd, {8'h0, ins});
      p = (i == 0) ? 15'h7fff : q[14:0];
      bus(1'b1, crd_pkg::R_PC, {17'h0, p});
      cmd(crd_pkg::CMD_EXIT_N, 2'h0, 16'h0);
      bus(1'b0, crd_pkg::R_PC, 32'h0);
      chk("exit_normal", rd, {17'h0, 15'(p + 15'h1)});
      cmd(crd_pkg::CMD_EXIT_S, 2'h0, 16'h0);
      bus(1'b0, crd_pkg::R_PC, 32'h0);
      chk("exit_skip", rd, {17'h0, 15'(p + 15'h3)});
      cmd(crd_pkg::CMD_EXIT_J, 2'h0, 16'h0);
      bus(1'b0, crd_pkg::R_PC, 32'h0);
      chk("exit_jump", rd, {17'h0, ins[14:0]});
      lat <= seed[1:0];
      bus(1'b1, crd_pkg::R_SADDR, {28'h0, 4'(i)});
      cmd(crd_pkg::CMD_SWEEP, 2'h0, 16'h0);
      bus(1'b0, crd_pkg::R_ENTRY, 32'h0);
      e = 24'(sword(4'(i + 1)));
      chk("sweep_entry", rd, {8'h0, e});
      bus(1'b0, crd_pkg::R_SDATA, 32'h0);
      chk("storage_data", rd, {4'h0, sword(4'(i + 1))});
      bus(1'b0, crd_pkg::R_SADDR, 32'h0);
      chk("storage_addr", rd, {28'h0, 4'(i + 1)});
    end
    bus(1'b1, crd_pkg::R_INSTR, {8'h0, 6'h17, 18'h0});
    cmd(crd_pkg::CMD_MASK, 2'h0, 16'h0);
    bus(1'b0, crd_pkg::R_ACC, 32'h0);
    chk("mask_and", rd, {8'h0, aq[47:24] & aq[23:0]});
    cmd(crd_pkg::CMD_IND, 2'h0, 16'h0);
    ins = {6'h17, e[17:0]};
    bus(1'b0, crd_pkg::R_INSTR, 32'h0);
    chk("indirect", rd, {8'h0, ins});
    bus(1'b1, crd_pkg::R_ACC, 32'h00ff_ffff);
    bus(1'b0, crd_pkg::R_ACC, 32'h0);
    chk("acc_posz", rd, 32'h0);
    for (int k = 0; k < 4; k++) begin
      cmd(crd_pkg::CMD_SETLEN, 2'h0, 16'(k == 0 ? 12 : k == 1 ? 13 : k == 2 ? 0 : 1));
      bus(1'b0, crd_pkg::R_FLEN, 32'h0);
      chk("field_len", rd, (k == 3) ? 32'h1 : 32'hc);
    end
    mode <= 3'b010;
    bus(1'b1, crd_pkg::R_ENTRY, {8'h0, q});
    bus(1'b0, crd_pkg::R_ENTRY, 32'h0);
    chk("entry_hold", rd, {8'h0, q});
    chk("disp_entry", {8'h0, console_disp}, {8'h0, q});
    cmd(crd_pkg::CMD_XFER, 2'h1, 16'h0);
    bus(1'b0, crd_pkg::R_AUX, 32'h0);
    chk("xfer_aux", rd, {8'h0, q});
    cmd(crd_pkg::CMD_BUFSH, 2'h0, 16'h1);
    bus(1'b0, crd_pkg::R_BUF, 32'h0);
    chk("buf_shift", rd, {8'h0, q[17:0], 6'h0});
    cmd(crd_pkg::CMD_KCLR, 2'h0, 16'h0);
    bus(1'b0, crd_pkg::R_ENTRY, 32'h0);
    chk("entry_clear", rd, 32'h0);
    mode <= 3'b000;
    bus(1'b1, crd_pkg::R_ENTRY, 32'h5);
    bus(1'b0, crd_pkg::R_ENTRY, 32'h0);
    chk("entry_locked", rd, 32'h0);
    chk("disp_instr", {8'h0, console_disp}, {8'h0, ins});
    give_verdict;
  end
endmodule // cpu_register_datapath_tb

/* tb/crd_stor_model.sv */
// Core storage model answering the datapath's storage port
`timescale 1ns/10ps
module crd_stor_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Storage port
  input  wire logic [12:0] stor_addr,
  input  wire logic [27:0] stor_wdata,
  input  wire logic        stor_we,
  input  wire logic        stor_re,
  input  wire logic [1:0]  lat,
  output logic      [27:0] stor_rdata,
  output logic             stor_ack
);
  logic [27:0] mem_r [16];
  logic [1:0]  cnt_r;
  function automatic logic [27:0] sword(input logic [3:0] i);
    logic [23:0] d;
    logic [3:0]  p;
    d = {6{i}} ^ 24'ha5c3e1;
    for (int k = 0; k < 4; k++) p[k] = ~^d[6*k+:6];
    return {p, d};
  endfunction
  // Data lines toggle outside an answer so stale words never look valid
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 2'h0;
      stor_ack <= 1'b0;
      stor_rdata <= 28'h0;
      for (int i = 0; i < 16; i++) mem_r[i] <= sword(4'(i));
    end else if ((stor_re || stor_we) && !stor_ack && cnt_r != lat) begin
      cnt_r <= cnt_r + 2'h1;
      stor_rdata <= ~stor_rdata;
    end else if ((stor_re || stor_we) && !stor_ack) begin
      cnt_r <= 2'h0;
      stor_ack <= 1'b1;
      if (stor_we) mem_r[stor_addr[3:0]] <= stor_wdata;
      stor_rdata <= stor_we ? ~stor_rdata : mem_r[stor_addr[3:0]];
    end else begin
      stor_ack <= 1'b0;
      stor_rdata <= ~stor_rdata;
    end
  end
endmodule // crd_stor_model
